// *** hw/pmc_power_ctrl.sv ***
// Power-mode controller: mode register, entry/exit sequencer, status and clock routing
//
// Functional notes
// - Standby stops core and scan clocks
// - Suspend clocks display RAM from xtal_ref
// - Sleep stops all clocks and PLLs
// - Clearing enter bit restores Normal mode
// - Status bit high in saving and wake, low after
// - Sleep stops oscillator only for parallel host
// - RAM power-down or self-refresh before Sleep
// - PLL lock reported in bit 7, 01h
// - Panel outputs idle in every saving mode
// - Inhibit bit covers reset, init, saving
`timescale 1ns/1ps
module pmc_power_ctrl (
	input wire logic clk, // System clock, 250 MHz
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [7:0] reg_addr, // Register address from command write
	input wire logic reg_wr, // Data write strobe, one cycle
	input wire logic reg_rd, // Data read strobe, one cycle
	input wire logic [7:0] reg_wdata, // Data write value
	output logic [7:0] reg_rdata, // Data read value
	input wire logic status_rd, // Status read strobe, one cycle
	output logic [7:0] status_rdata, // Chip state value
	input wire logic host_is_serial, // Host interface is serial
	input wire logic int_reset_busy, // Internal reset sequence running
	input wire logic init_display_busy, // Initial display running
	input wire logic core_pll_lock, // Core PLL locked
	input wire logic mem_pll_lock, // Memory PLL locked
	input wire logic scan_pll_lock, // Scan PLL locked
	input wire logic ram_park_ack, // Display RAM reached requested low-power state
	output logic ram_power_down_req, // Request RAM power-down
	output logic ram_self_refresh_req, // Request RAM self-refresh
	output logic core_pll_en, // Core PLL power
	output logic mem_pll_en, // Memory PLL power
	output logic scan_pll_en, // Scan PLL power
	output logic xtal_en, // Crystal oscillator enable
	output logic core_clk_en, // Core clock gate
	output logic mem_clk_en, // Display RAM clock gate
	output logic mem_clk_sel_xtal, // Display RAM clock source is xtal_ref
	output logic scan_clk_en, // Panel scan clock gate
	output logic panel_drive_en, // Panel interface output enable
	output logic saving_active // Power-saving mode reached
);
	import pmc_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] power_mode_control_reg;
	logic ram_self_refresh_reg;
	pmc_state_t state_reg;
	pmc_state_t state_next;
	pmc_mode_t active_mode_reg;
	logic park_req_reg;
	logic inhibit_reg;
	logic enter_req;
	pmc_mode_t req_mode;
	logic all_locked;

	assign enter_req = power_mode_control_reg[PMC_PWR_ENTER_BIT];
	assign req_mode = pmc_mode_t'(power_mode_control_reg[PMC_PWR_MODE_MSB:PMC_PWR_MODE_LSB]);
	assign all_locked = core_pll_lock & mem_pll_lock & scan_pll_lock;

	// Mode bits and enter bit come in one write; each write reloads both, so the enter bit acts on the mode written with it
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			power_mode_control_reg <= PMC_POWER_MODE_RESET;
		end else if (reg_wr && reg_addr == PMC_ADDR_POWER_MODE) begin
			power_mode_control_reg <= {reg_wdata[PMC_PWR_ENTER_BIT], 5'h00,
				reg_wdata[PMC_PWR_MODE_MSB:PMC_PWR_MODE_LSB]};
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ram_self_refresh_reg <= PMC_RAM_CTRL_RESET[PMC_RAM_SELF_REFRESH_BIT];
		end else if (reg_wr && reg_addr == PMC_ADDR_RAM_CTRL) begin
			ram_self_refresh_reg <= reg_wdata[PMC_RAM_SELF_REFRESH_BIT];
		end
	end

	// ****************************************
	// Entry and exit sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PMC_ST_NORMAL: begin
				// Mode 00 with enter set stays in Normal
				if (enter_req && req_mode != PMC_MODE_NORMAL) begin
					if (req_mode == PMC_MODE_SLEEP) begin
						state_next = PMC_ST_RAM_PARK;
					end else begin
						state_next = PMC_ST_SAVING;
					end
				end
			end
			PMC_ST_RAM_PARK: begin
				if (!enter_req) begin
					state_next = PMC_ST_WAKE;
				end else if (ram_park_ack) begin
					state_next = PMC_ST_SAVING;
				end
			end
			PMC_ST_SAVING: begin
				if (!enter_req) begin
					state_next = PMC_ST_WAKE;
				end
			end
			PMC_ST_WAKE: begin
				// Clocks are only released once every PLL reports lock
				if (all_locked) begin
					state_next = PMC_ST_NORMAL;
				end
			end
			default: state_next = PMC_ST_NORMAL;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= PMC_ST_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// Mode is frozen at entry so rewriting bits 1:0 mid-saving has no effect
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			active_mode_reg <= PMC_MODE_NORMAL;
		end else if (state_reg == PMC_ST_NORMAL && state_next != PMC_ST_NORMAL) begin
			active_mode_reg <= req_mode;
		end
	end

	// ****************************************
	// Display RAM park request
	// ****************************************
	// Held through Sleep; dropped on wake so the RAM controller resumes first
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			park_req_reg <= 1'b0;
		end else begin
			park_req_reg <= state_next == PMC_ST_RAM_PARK ||
				(state_next == PMC_ST_SAVING && park_req_reg);
		end
	end

	assign ram_power_down_req = park_req_reg & ~ram_self_refresh_reg;
	assign ram_self_refresh_req = park_req_reg & ram_self_refresh_reg;

	// ****************************************
	// Status and inhibit
	// ****************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inhibit_reg <= 1'b0;
		end else begin
			// Held through wake so the host does not see Normal before the PLLs relock
			inhibit_reg <= int_reset_busy | init_display_busy | (state_next == PMC_ST_SAVING) |
				(state_next == PMC_ST_WAKE);
		end
	end

	assign saving_active = (state_reg == PMC_ST_SAVING);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			status_rdata <= 8'h00;
		end else if (status_rd) begin
			status_rdata <= 8'h00;
			status_rdata[PMC_STATE_INHIBIT_BIT] <= inhibit_reg;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	// Addresses outside this block read as zero; the enclosing mux owns them
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				PMC_ADDR_POWER_MODE: reg_rdata <= power_mode_control_reg;
				PMC_ADDR_RAM_CTRL: reg_rdata <= {ram_self_refresh_reg, 7'h00};
				PMC_ADDR_CHIP_CFG: reg_rdata <= {all_locked, 7'h00};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Clock routing
	// ****************************************
	// The oscillator is forced back on in wake, covering the restart the host must also request
	pmc_clk_route u_route (
		.clk(clk),
		.reset_n(reset_n),
		.state(state_reg),
		.mode(active_mode_reg),
		.host_is_serial(host_is_serial),
		.core_pll_en(core_pll_en),
		.mem_pll_en(mem_pll_en),
		.scan_pll_en(scan_pll_en),
		.xtal_en(xtal_en),
		.core_clk_en(core_clk_en),
		.mem_clk_en(mem_clk_en),
		.mem_clk_sel_xtal(mem_clk_sel_xtal),
		.scan_clk_en(scan_clk_en),
		.panel_drive_en(panel_drive_en)
	);

endmodule // pmc_power_ctrl

// *** inc/pmc_pkg.sv ***
// Package: register map, field positions, mode codes and states of the power-mode controller
package pmc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] PMC_ADDR_CHIP_CFG = 8'h01;
	localparam logic [7:0] PMC_ADDR_POWER_MODE = 8'hdf;
	localparam logic [7:0] PMC_ADDR_RAM_CTRL = 8'he0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PMC_PWR_ENTER_BIT = 7;
	localparam int PMC_PWR_MODE_LSB = 0;
	localparam int PMC_PWR_MODE_MSB = 1;
	localparam int PMC_RAM_SELF_REFRESH_BIT = 7;
	localparam int PMC_CFG_PLL_LOCK_BIT = 7;
	localparam int PMC_STATE_INHIBIT_BIT = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] PMC_POWER_MODE_RESET = 8'h00;
	localparam logic [7:0] PMC_RAM_CTRL_RESET = 8'h00;

	// ****************************************
	// Mode codes and controller states
	// ****************************************
	typedef enum logic [1:0] {
		PMC_MODE_NORMAL = 2'h0,
		PMC_MODE_STANDBY = 2'h1,
		PMC_MODE_SUSPEND = 2'h2,
		PMC_MODE_SLEEP = 2'h3
	} pmc_mode_t;

	typedef enum logic [3:0] {
		PMC_ST_NORMAL = 4'h1,
		PMC_ST_RAM_PARK = 4'h2,
		PMC_ST_SAVING = 4'h4,
		PMC_ST_WAKE = 4'h8
	} pmc_state_t;

endpackage

// *** hw/pmc_clk_route.sv ***
// Clock gating, clock source and PLL/oscillator enables derived from controller state
`timescale 1ns/1ps
module pmc_clk_route (
	input wire logic clk, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire pmc_pkg::pmc_state_t state, // Controller state
	input wire pmc_pkg::pmc_mode_t mode, // Latched saving mode
	input wire logic host_is_serial, // High when host interface is serial
	output logic core_pll_en, // Core PLL power
	output logic mem_pll_en, // Memory PLL power
	output logic scan_pll_en, // Scan PLL power
	output logic xtal_en, // Crystal oscillator enable
	output logic core_clk_en, // Core clock gate
	output logic mem_clk_en, // Display RAM clock gate
	output logic mem_clk_sel_xtal, // Display RAM clock from xtal_ref
	output logic scan_clk_en, // Panel scan clock gate
	output logic panel_drive_en // Panel interface output enable
);
	import pmc_pkg::*;

	logic [8:0] route_next;

	// ****************************************
	// Route decode
	// ****************************************
	// Order: core_pll, mem_pll, scan_pll, xtal, core, mem, mem_xtal, scan, panel
	always_comb begin
		route_next = 9'h1fb;
		case (state)
			PMC_ST_NORMAL: begin
				route_next = 9'h1fb;
			end
			PMC_ST_RAM_PARK: begin
				// Memory clock runs on so the RAM can finish parking
				route_next = 9'h1e8;
			end
			PMC_ST_SAVING: begin
				case (mode)
					PMC_MODE_STANDBY: route_next = 9'h1e8;
					PMC_MODE_SUSPEND: route_next = 9'h02c;
					PMC_MODE_SLEEP: route_next = {3'h0, host_is_serial, 5'h00};
					default: route_next = 9'h1fb;
				endcase
			end
			PMC_ST_WAKE: begin
				// PLLs and oscillator back on; core and scan clocks stay gated until lock
				case (mode)
					PMC_MODE_STANDBY: route_next = 9'h1e8;
					PMC_MODE_SUSPEND: route_next = 9'h1ec;
					default: route_next = 9'h1e0;
				endcase
			end
			default: route_next = 9'h1fb;
		endcase
	end

	// Registered so gate enables never glitch on a state change
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			{core_pll_en, mem_pll_en, scan_pll_en, xtal_en, core_clk_en, mem_clk_en, mem_clk_sel_xtal,
				scan_clk_en, panel_drive_en} <= 9'h1fb;
		end else begin
			{core_pll_en, mem_pll_en, scan_pll_en, xtal_en, core_clk_en, mem_clk_en, mem_clk_sel_xtal,
				scan_clk_en, panel_drive_en} <= route_next;
		end
	end

endmodule // pmc_clk_route

// *** verif/pmc_plant_model.sv ***
// PLL and display RAM stand-ins that answer the controller's enables and requests
`timescale 1ns/1ps
module pmc_plant_model #(
	parameter int LOCK_DLY = 6 // Cycles from enable to lock
) (
	input wire logic clk, // Clock
	input wire logic [2:0] pll_en, // Core, mem, scan PLL power
	input wire logic park_req, // RAM low-power request
	output logic [2:0] pll_lock, // Lock flags
	output logic ram_park_ack // RAM parked
);
	logic [7:0] cnt [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] ack_cnt = 8'h00;
	// A PLL that is switched off loses lock at once, so a wake must wait out the full delay
	always_ff @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			// Unknown enables before the first reset edge count as off, so no unknown sticks
			cnt[i] <= (pll_en[i] === 1'b1) ? cnt[i] + 8'(cnt[i] < 8'(LOCK_DLY)) : 8'h00;
		end
		ack_cnt <= (park_req === 1'b1) ? ack_cnt + 8'(ack_cnt < 8'h03) : 8'h00;
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pll_lock[i] = cnt[i] >= 8'(LOCK_DLY);
		end
	end
	assign ram_park_ack = ack_cnt == 8'h03;
endmodule // pmc_plant_model

// *** verif/pmc_power_ctrl_chk.sv ***
// Checker: port assertions of the power-mode controller
`timescale 1ns/1ps
module pmc_power_ctrl_chk
	import pmc_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic reset_n, // Reset, low
	input wire logic [7:0] reg_addr, // Address
	input wire logic reg_wr, // Write
	input wire logic reg_rd, // Read
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic status_rd, // Status read
	input wire logic [7:0] status_rdata, // Status
	input wire logic host_is_serial, // Serial host
	input wire logic int_reset_busy, // Reset busy
	input wire logic init_display_busy, // Init busy
	input wire logic core_pll_lock, // Lock
	input wire logic mem_pll_lock, // Lock
	input wire logic scan_pll_lock, // Lock
	input wire logic core_pll_en, // PLL on
	input wire logic mem_pll_en, // PLL on
	input wire logic scan_pll_en, // PLL on
	input wire logic xtal_en, // Oscillator on
	input wire logic core_clk_en, // Gate
	input wire logic mem_clk_en, // Gate
	input wire logic mem_clk_sel_xtal, // RAM clock source
	input wire logic scan_clk_en, // Gate
	input wire logic panel_drive_en, // Panel on
	input wire logic saving_active // Saving
);
	logic sv_q;
	logic lk_q;
	logic wk_q;
	wire held = saving_active && sv_q;
	// Route outputs trail the state by one cycle, so judge them from the second saving cycle
	// wk_q follows the wake phase: from leaving saving until all locks were seen
	always_ff @(posedge clk) begin
		sv_q <= reset_n && saving_active;
		lk_q <= core_pll_lock && mem_pll_lock && scan_pll_lock;
		wk_q <= reset_n && ((sv_q && !saving_active) || (wk_q && !lk_q));
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_core_scan_stop: assert property (held |-> !core_clk_en && !scan_clk_en)
		else $error("core or scan clock running while saving");
	a_panel_idle: assert property (held |-> !panel_drive_en)
		else $error("panel driven while saving");
	a_sleep_xtal: assert property (held && !mem_clk_en && $stable(host_is_serial) |->
		xtal_en == host_is_serial && !mem_pll_en && !core_pll_en) else $error("sleep clocks wrong");
	a_suspend_src: assert property (held && mem_clk_sel_xtal |-> mem_clk_en && xtal_en
		&& !core_pll_en && !mem_pll_en && !scan_pll_en) else $error("suspend clocks wrong");
	a_standby_mem: assert property (held && mem_pll_en |-> mem_clk_en && !mem_clk_sel_xtal
		&& core_pll_en && scan_pll_en) else $error("standby clocks wrong");
	a_status_bit: assert property (status_rd && !int_reset_busy && !init_display_busy
		&& !$past(int_reset_busy) && !$past(init_display_busy)
		|=> status_rdata == {6'h00, $past(saving_active) || wk_q, 1'b0}) else $error("status bit wrong");
	a_lock_read: assert property (reg_rd && reg_addr == PMC_ADDR_CHIP_CFG |=>
		reg_rdata[7] == $past(core_pll_lock && mem_pll_lock && scan_pll_lock)) else $error("lock bit wrong");
	a_exit_bound: assert property (held && reg_wr && reg_addr == PMC_ADDR_POWER_MODE && !reg_wdata[7]
		|-> ##[1:60] panel_drive_en) else $error("no return to normal");
endmodule // pmc_power_ctrl_chk
bind pmc_power_ctrl pmc_power_ctrl_chk i_chk (.*);

// *** verif/power_mode_clock_gating_tb.sv ***
// Testbench: register access and random mode entry and exit of the power-mode controller
`timescale 1ns/1ps
module power_mode_clock_gating_tb;
	import pmc_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, status_rd = 1'b0;
	logic serial = 1'b0, rst_busy = 1'b0, init_busy = 1'b0, srf, saw_pd, saw_sr;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, status_rdata, v;
	logic [2:0] lk;
	logic [1:0] m;
	logic ack, pd, sr, cpe, mpe, spe, xe, ce, me, mx, se, pe, sa;
	int fails = 0, checked = 0, seed = 32'hb27d4f1d;
	wire [8:0] route = {cpe, mpe, spe, xe, ce, me, mx, se, pe};
	always #2 clk = ~clk;
	pmc_power_ctrl i_pmc_power_ctrl (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status_rd(status_rd),
		.status_rdata(status_rdata), .host_is_serial(serial), .int_reset_busy(rst_busy),
		.init_display_busy(init_busy), .core_pll_lock(lk[2]), .mem_pll_lock(lk[1]), .scan_pll_lock(lk[0]),
		.ram_park_ack(ack), .ram_power_down_req(pd), .ram_self_refresh_req(sr), .core_pll_en(cpe),
		.mem_pll_en(mpe), .scan_pll_en(spe), .xtal_en(xe), .core_clk_en(ce), .mem_clk_en(me),
		.mem_clk_sel_xtal(mx), .scan_clk_en(se), .panel_drive_en(pe), .saving_active(sa));
	pmc_plant_model i_pmc_plant_model (.clk(clk), .pll_en({cpe, mpe, spe}), .park_req(pd | sr),
		.pll_lock(lk), .ram_park_ack(ack));
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic st;
		@(posedge clk);
		status_rd <= 1'b1;
		@(posedge clk);
		status_rd <= 1'b0;
		#1 v = status_rdata;
	endtask
	// Polls the status bit and notes any RAM request seen on the way
	task automatic poll(input logic b);
		for (int i = 0; i < 40; i++) begin
			st();
			saw_pd |= pd;
			saw_sr |= sr;
			if (v[1] === b) break;
		end
		check(v[1], b);
		if (v[1] !== b) give_verdict();
	endtask
	function automatic logic [8:0] exp_route(input logic [1:0] md, input logic s);
		case (md)
			2'h1: return 9'h1e8;
			2'h2: return 9'h02c;
			2'h3: return {3'h0, s, 5'h00};
			default: return 9'h1fb;
		endcase
	endfunction
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		rd(PMC_ADDR_POWER_MODE, v);
		check(v, PMC_POWER_MODE_RESET);
		wr(PMC_ADDR_RAM_CTRL, 8'hff);
		rd(PMC_ADDR_RAM_CTRL, v);
		check(v, 8'h80);
		wr(8'h55, 8'hff);
		rd(8'h55, v);
		check(v, 8'h00);
		repeat (10) @(posedge clk);
		rd(PMC_ADDR_CHIP_CFG, v);
		check(v[7], 1'b1);
		for (int b = 0; b < 2; b++) begin
			{init_busy, rst_busy} <= b ? 2'b10 : 2'b01;
			st();
			st();
			check(v, 8'h02);
			{init_busy, rst_busy} <= 2'b00;
			st();
			check(v, 8'h00);
		end
		$display("test registers done");
		for (int n = 0; n < 14; n++) begin
			m = (n < 4) ? n[1:0] : 2'($random(seed));
			serial <= 1'($random(seed));
			srf = 1'($random(seed));
			wr(PMC_ADDR_RAM_CTRL, {srf, 7'h00});
			wr(PMC_ADDR_POWER_MODE, {1'b0, 5'($random(seed)), m});
			rd(PMC_ADDR_POWER_MODE, v);
			check(v, {6'h00, m});
			saw_pd = 1'b0;
			saw_sr = 1'b0;
			wr(PMC_ADDR_POWER_MODE, {6'h20, m});
			if (m == 2'h0) begin
				repeat (6) @(posedge clk);
				st();
				check(v, 8'h00);
			end else begin
				poll(1'b1);
				repeat (2) @(posedge clk);
				check(route, exp_route(m, serial));
				check({saw_sr, saw_pd}, (m == 2'h3) ? {srf, !srf} : 2'b00);
			end
			wr(PMC_ADDR_POWER_MODE, 8'h00);
			poll(1'b0);
			repeat (2) @(posedge clk);
			check(route, 9'h1fb);
			$display("test mode %0d done", m);
		end
		give_verdict();
	end
	initial begin
		#200000;
		fails++;
		give_verdict();
	end
endmodule // power_mode_clock_gating_tb
